// *** hdl/dac_params.svh ***
// Purpose: offsets, field positions and reset values of the descriptor access checker
// Assumes: Avalon-MM slave with 32-bit data and byte addresses
// Notes: definitions only
`ifndef DAC_PARAMS_SVH
`define DAC_PARAMS_SVH
// register byte offsets
`define DAC_OFS_CTRL 8'h00
`define DAC_OFS_SEGW0 8'h04
`define DAC_OFS_SEGW1 8'h08
`define DAC_OFS_PAGEW 8'h0c
`define DAC_OFS_VADDR 8'h10
`define DAC_OFS_STATUS 8'h14
`define DAC_OFS_PADDR 8'h18
`define DAC_OFS_CFG 8'h1c
`define DAC_OFS_CSEL 8'h20
`define DAC_OFS_CLO 8'h24
`define DAC_OFS_CHI 8'h28
// segment entry, first word; base field of the second word
`define DAC_SEG_CONTIG 2
`define DAC_SEG_TRAP 4
`define DAC_SEG_REF 5
`define DAC_SEG_VALID 6
`define DAC_SEG_INDIR 7
`define DAC_SEG_MAXOFF_LO 10
`define DAC_SEG_MAXOFF_HI 23
`define DAC_SEG_BASE_LO 5
// page entry
`define DAC_PG_PRESENT 0
`define DAC_PG_MOD 1
`define DAC_PG_LAST 2
`define DAC_PG_WFAULT 4
`define DAC_PG_BASE_LO 11
// control and configuration registers
`define DAC_CTRL_GO 31
`define DAC_CTRL_RST 6'h00
`define DAC_CFG_RST 2'h0
`endif

// *** hdl/dac_pkg.sv ***
// Purpose: types of the descriptor access checker
// Assumes: nothing
// Notes: enums carry no explicit codes except where software sees them
package dac_pkg;
	typedef enum logic [1:0] {
		NO_PERMISSION = 2'h0,
		RUN_ONLY_PERMISSION = 2'h1,
		LOAD_AND_RUN_PERMISSION = 2'h2,
		FULL_PERMISSION = 2'h3
	} dac_perm_t;
	typedef enum logic [2:0] {
		ACC_INTERLOCKED = 3'h0,
		ACC_ADDR_FETCH = 3'h1,
		ACC_OPERAND_FETCH = 3'h2,
		ACC_WRITE = 3'h3,
		ACC_INSTR_FETCH = 3'h4,
		ACC_INSTR_DISC = 3'h5,
		ACC_PREFETCH = 3'h6,
		MOVE_TRANSLATED_OP = 3'h7
	} dac_access_t;
	typedef struct packed {
		logic periph;
		dac_access_t acc;
		logic [1:0] level;
	} dac_ctrl_t;
	typedef struct packed {
		logic lastPage;
		logic modified;
		logic referenced;
		logic writeFault;
		logic pageAbsent;
		logic objTrap;
		logic lengthFault;
		logic indirect;
		logic invalid;
		logic accessFault;
		logic done;
	} dac_status_t;
endpackage

// *** hdl/dac_descriptor_access_check.sv ***
// Purpose: descriptor decode and permission check behind an Avalon-MM slave
// Assumes: software loads descriptor words and a virtual address, then writes go
// Notes: results appear in status one cycle after the go write is accepted
//
// Register access over Avalon-MM and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "dac_params.svh"

// Operation
// R01: trap bit 4 faults when permitted and segment contiguous.
// R02: segment bit 5 referenced counts only with configuration referenced bit.
// R03: segment entry usable only when bit 6 is one.
// R04: bit 7 set means entry points to another segment entry.
// R05: software keeps segment entry bits 8 and 9 zero.
// R06: bits 10 to 23 bound the allowed byte offset.
// R07: rights bits 24-31, kernel high pair down to user low pair.
// R08: codes 00 none, 01 run, 10 load and run, 11 full.
// R09: each access type accepts only its listed permission codes.
// R10: caches reachable only in peripheral mode.
// R11: segment cache holds 32 entries of 64 bits, four sections.
// R12: page cache holds 64 entries, two ways, four sections.
// R13: page bit 0 one means present, zero means absent.
// R14: page bit 1 one means page was written.
// R15: page bit 2 marks short last page of segment.
// R16: software keeps page bits 3, 6 and 7 zero.
// R17: access fault when level's code forbids the requested access.
// R18: segment bit 2 selects contiguous, otherwise paged.
// R19: paged address joins page base with byte_within_page bits.
// R20: execution level selects the rights slice used.
// R21: page bit 4 faults write attempts to the page.
module dac_descriptor_access_check #(
	parameter int SEG_ENTRIES = 32,
	parameter int PAGE_ENTRIES = 64
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// avalon-mm slave
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// status to the processor side
	output logic faultOut
);
	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	dac_pkg::dac_ctrl_t ctrl;
	dac_pkg::dac_status_t status;
	logic [31:0] segW0;
	logic [31:0] segW1;
	logic [31:0] pageW;
	logic [31:0] vaddr;
	logic [31:0] paddr;
	logic [1:0] cfg;
	logic [6:0] cacheSel;
	logic [31:0] cacheLo;
	logic ack;
	logic pending;
	logic [63:0] segCache [SEG_ENTRIES];
	logic [63:0] pageCache [PAGE_ENTRIES];

	logic req;
	logic wrDo;
	assign req = read | write;
	// one wait cycle per request keeps the read path fully registered
	assign waitrequest = req & ~ack;
	assign wrDo = write & ack;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ack <= 1'b0;
		end else begin
			ack <= req & ~ack;
		end
	end

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic logic permits(input dac_pkg::dac_perm_t code, input dac_pkg::dac_access_t acc);
		logic ok;
		ok = 1'b0;
		case (acc) // R09
			dac_pkg::ACC_INTERLOCKED, dac_pkg::ACC_WRITE: begin
				ok = (code == dac_pkg::FULL_PERMISSION);
			end
			dac_pkg::ACC_ADDR_FETCH, dac_pkg::ACC_OPERAND_FETCH, dac_pkg::MOVE_TRANSLATED_OP: begin
				ok = (code == dac_pkg::FULL_PERMISSION) || (code == dac_pkg::LOAD_AND_RUN_PERMISSION);
			end
			default: begin
				ok = (code != dac_pkg::NO_PERMISSION); // R08
			end
		endcase
		return ok;
	endfunction

	function automatic dac_pkg::dac_perm_t rightsOf(input logic [31:0] w0, input logic [1:0] lvl);
		logic [7:0] acc;
		acc = w0[31:24]; // R07
		// level 3 is kernel, 0 is user
		return dac_pkg::dac_perm_t'(acc[{lvl, 1'b0} +: 2]); // R20
	endfunction

	function automatic logic isCacheReg(input logic [7:0] a);
		return (a == `DAC_OFS_CLO) || (a == `DAC_OFS_CHI);
	endfunction

	// ----------------------------------------------------------------
	// translation check
	// ----------------------------------------------------------------
	dac_pkg::dac_perm_t perm;
	logic permOk;
	logic contig;
	logic [13:0] maxOff;
	logic [16:0] segOff;
	logic lenBad;
	logic lastBad;
	logic isWrite;
	dac_pkg::dac_status_t next_status;
	logic [31:0] next_paddr;

	assign perm = rightsOf(segW0, ctrl.level);
	assign permOk = permits(perm, ctrl.acc); // R17
	assign contig = segW0[`DAC_SEG_CONTIG]; // R18
	assign maxOff = segW0[`DAC_SEG_MAXOFF_HI:`DAC_SEG_MAXOFF_LO];
	assign segOff = vaddr[16:0];
	// offsets are checked in 8-byte granules
	assign lenBad = segOff[16:3] > maxOff; // R06
	assign lastBad = pageW[`DAC_PG_LAST] && (segOff[10:3] > maxOff[7:0]); // R15
	assign isWrite = (ctrl.acc == dac_pkg::ACC_WRITE) || (ctrl.acc == dac_pkg::ACC_INTERLOCKED);

	always_comb begin
		next_status = '0;
		next_status.done = 1'b1;
		next_paddr = '0;
		next_status.referenced = segW0[`DAC_SEG_REF] & cfg[0]; // R02
		if (!segW0[`DAC_SEG_VALID]) begin
			next_status.invalid = 1'b1; // R03
		end else if (segW0[`DAC_SEG_INDIR]) begin
			// another entry must be fetched; nothing else is judged here
			next_status.indirect = 1'b1; // R04
			next_paddr = {segW1[31:3], 3'h0};
		end else if (!permOk) begin
			next_status.accessFault = 1'b1; // R17
		end else if (lenBad) begin
			next_status.lengthFault = 1'b1; // R06
		end else if (contig) begin
			next_status.objTrap = segW0[`DAC_SEG_TRAP]; // R01
			next_paddr = {segW1[31:`DAC_SEG_BASE_LO], 5'h00} + {15'h0000, segOff};
		end else if (!pageW[`DAC_PG_PRESENT]) begin
			next_status.pageAbsent = 1'b1; // R13
		end else if (isWrite && pageW[`DAC_PG_WFAULT]) begin
			next_status.writeFault = 1'b1; // R21
		end else if (lastBad) begin
			next_status.lengthFault = 1'b1; // R15
		end else begin
			next_paddr = {pageW[31:`DAC_PG_BASE_LO], vaddr[10:0]}; // R19
			next_status.modified = pageW[`DAC_PG_MOD] | isWrite; // R14
		end
		next_status.lastPage = ~contig & pageW[`DAC_PG_LAST]; // R15
	end

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl <= dac_pkg::dac_ctrl_t'(`DAC_CTRL_RST);
			cfg <= `DAC_CFG_RST;
			segW0 <= 32'h0000_0000;
			segW1 <= 32'h0000_0000;
			pageW <= 32'h0000_0000;
			vaddr <= 32'h0000_0000;
			cacheSel <= 7'h00;
			cacheLo <= 32'h0000_0000;
		end else if (wrDo) begin
			if (address == `DAC_OFS_CTRL) begin
				ctrl <= dac_pkg::dac_ctrl_t'(writedata[5:0]);
			end else if (address == `DAC_OFS_SEGW0) begin
				segW0 <= writedata;
			end else if (address == `DAC_OFS_SEGW1) begin
				segW1 <= writedata;
			end else if (address == `DAC_OFS_PAGEW) begin
				pageW <= writedata;
			end else if (address == `DAC_OFS_VADDR) begin
				vaddr <= writedata;
			end else if (address == `DAC_OFS_CFG) begin
				cfg <= writedata[1:0];
			end else if (address == `DAC_OFS_CSEL) begin
				cacheSel <= writedata[6:0];
			end else if (address == `DAC_OFS_CLO && ctrl.periph) begin
				cacheLo <= writedata; // R10
			end
		end
	end

	// go starts a check on the cycle after the write so new ctrl is settled
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pending <= 1'b0;
		end else begin
			pending <= wrDo && (address == `DAC_OFS_CTRL) && writedata[`DAC_CTRL_GO];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			status <= '0;
			paddr <= 32'h0000_0000;
		end else if (pending) begin
			status <= next_status;
			paddr <= next_paddr;
		end
	end

	assign faultOut = status.accessFault | status.invalid | status.lengthFault |
		status.objTrap | status.pageAbsent | status.writeFault;

	// ----------------------------------------------------------------
	// descriptor caches
	// ----------------------------------------------------------------
	// segment cache index is {section, entry[2:0]}; page cache index is
	// {section, set[2:0], way}, so each section owns eight sets of two ways
	logic cacheWr;
	assign cacheWr = wrDo && (address == `DAC_OFS_CHI) && ctrl.periph; // R10

	always_ff @(posedge sys_clk) begin
		if (cacheWr && !cacheSel[6]) begin
			segCache[cacheSel[4:0]] <= {writedata, cacheLo}; // R11
		end
	end

	always_ff @(posedge sys_clk) begin
		if (cacheWr && cacheSel[6]) begin
			pageCache[cacheSel[5:0]] <= {writedata, cacheLo}; // R12
		end
	end

	logic [63:0] cacheWord;
	assign cacheWord = cacheSel[6] ? pageCache[cacheSel[5:0]] : segCache[cacheSel[4:0]];

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	logic [31:0] next_readdata;
	always_comb begin
		next_readdata = 32'h0000_0000;
		if (address == `DAC_OFS_CTRL) begin
			next_readdata = {26'h0000000, ctrl};
		end else if (address == `DAC_OFS_SEGW0) begin
			next_readdata = segW0;
		end else if (address == `DAC_OFS_SEGW1) begin
			next_readdata = segW1;
		end else if (address == `DAC_OFS_PAGEW) begin
			next_readdata = pageW;
		end else if (address == `DAC_OFS_VADDR) begin
			next_readdata = vaddr;
		end else if (address == `DAC_OFS_STATUS) begin
			// a read right behind the go write sees the result that is being stored
			next_readdata = {21'h000000, (pending ? next_status : status)};
		end else if (address == `DAC_OFS_PADDR) begin
			next_readdata = pending ? next_paddr : paddr;
		end else if (address == `DAC_OFS_CFG) begin
			next_readdata = {30'h00000000, cfg};
		end else if (address == `DAC_OFS_CSEL) begin
			next_readdata = {25'h0000000, cacheSel};
		end else if (isCacheReg(address) && ctrl.periph) begin
			// outside peripheral mode the caches read as zero
			next_readdata = (address == `DAC_OFS_CLO) ? cacheWord[31:0] : cacheWord[63:32]; // R10
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			readdata <= 32'h0000_0000;
		end else if (read && !ack) begin
			readdata <= next_readdata;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_invalid;
		@(posedge sys_clk) disable iff (rst)
		pending && !segW0[`DAC_SEG_VALID] |=> status.invalid && !status.accessFault;
	endproperty
	a_invalid: assert property (p_invalid) else $error("invalid entry not flagged"); // R03

	property p_indirect;
		@(posedge sys_clk) disable iff (rst)
		pending && segW0[`DAC_SEG_VALID] && segW0[`DAC_SEG_INDIR] |=> status.indirect && !faultOut;
	endproperty
	a_indirect: assert property (p_indirect) else $error("indirect entry not reported"); // R04

	property p_access;
		@(posedge sys_clk) disable iff (rst)
		pending && segW0[`DAC_SEG_VALID] && !segW0[`DAC_SEG_INDIR] && segW0[31:24] == 8'h00
		|=> status.accessFault && faultOut;
	endproperty
	a_access: assert property (p_access) else $error("no-permission access passed"); // R17

	property p_write_full;
		@(posedge sys_clk) disable iff (rst)
		pending && isWrite && segW0[`DAC_SEG_VALID] && !segW0[`DAC_SEG_INDIR] &&
		perm != dac_pkg::FULL_PERMISSION |=> status.accessFault;
	endproperty
	a_write_full: assert property (p_write_full) else $error("write passed without full rights"); // R09

	property p_trap;
		@(posedge sys_clk) disable iff (rst)
		pending && segW0[`DAC_SEG_VALID] && !segW0[`DAC_SEG_INDIR] && permOk && !lenBad && contig
		&& segW0[`DAC_SEG_TRAP]
		|=> status.objTrap && faultOut;
	endproperty
	a_trap: assert property (p_trap) else $error("object trap missed"); // R01

	property p_page_join;
		@(posedge sys_clk) disable iff (rst)
		pending && segW0[`DAC_SEG_VALID] && !segW0[`DAC_SEG_INDIR] && permOk && !lenBad
		&& !contig && pageW[`DAC_PG_PRESENT] && !(isWrite && pageW[`DAC_PG_WFAULT])
		&& !lastBad
		|=> paddr[10:0] == $past(vaddr[10:0]) && paddr[31:11] == $past(pageW[31:11]);
	endproperty
	a_page_join: assert property (p_page_join) else $error("paged address not joined"); // R19

	property p_absent;
		@(posedge sys_clk) disable iff (rst)
		pending && segW0[`DAC_SEG_VALID] && !segW0[`DAC_SEG_INDIR] && permOk && !lenBad
		&& !contig && !pageW[`DAC_PG_PRESENT] |=> status.pageAbsent ##1 faultOut;
	endproperty
	a_absent: assert property (p_absent) else $error("absent page not flagged"); // R13

	property p_cache_locked;
		@(posedge sys_clk) disable iff (rst)
		read && !ack && isCacheReg(address) && !ctrl.periph |=> readdata == 32'h0000_0000;
	endproperty
	a_cache_locked: assert property (p_cache_locked) else $error("cache read outside periph"); // R10

	property p_ack;
		@(posedge sys_clk) disable iff (rst)
		$rose(req) |-> waitrequest ##1 !waitrequest;
	endproperty
	a_ack: assert property (p_ack) else $error("bus answer not after one wait cycle");
endmodule

// *** dv/dac_host_model.sv ***
// Purpose: host master model on the avalon-mm side of the access checker
// Assumes: one request at a time, issued only after reset is released
// Notes: hung flags a request that never saw waitrequest low
`timescale 1ns/1ps
module dac_host_model (
	// clock
	input wire logic sys_clk,
	// avalon-mm master
	output logic [7:0] address,
	output logic read,
	output logic write,
	output logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic waitrequest
);
	logic hung;
	initial begin
		address = 8'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		hung = 1'b0;
	end
	// waitrequest and readdata are sampled at the rising edge itself; the request is
	// released right after the edge that sees waitrequest low, then one edge passes
	task automatic xfer(input logic isWr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		address <= a;
		writedata <= d;
		write <= isWr;
		read <= ~isWr;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		q = readdata;
		hung = (waitrequest !== 1'b0);
		write <= 1'b0;
		read <= 1'b0;
		@(posedge sys_clk);
	endtask
endmodule

// *** dv/dac_descriptor_access_check_tb_top.sv ***
// Purpose: self-checking bench of the descriptor access checker
// Assumes: registers as laid out in dac_params.svh
// Notes: random descriptors with fixed seed plus a table of corner cases
`timescale 1ns/1ps
`include "dac_params.svh"
module dac_descriptor_access_check_tb_top;
	logic sysClk;
	logic rst;
	logic [7:0] address;
	logic read;
	logic write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic waitrequest;
	logic faultOut;
	int failCount;
	int checkCount;
	int seed;
	logic [31:0] segW0, segW1, pageW, vaddr, ctrlW, cfgW, rd, st;
	logic [31:0] cw0 [11] = '{32'hff004044, 32'hff004044, 32'hff004054, 32'h3f004054,
		32'hfffffc60, 32'hfffffc60, 32'hfffffc60, 32'hff0c1040, 32'hff0000c0, 32'hff0000a0,
		32'h00004044};
	logic [31:0] cpg [11] = '{0, 0, 0, 0, 32'habcde801, 32'habcde800, 32'habcde811,
		32'habcde805, 0, 0, 0};
	logic [31:0] cva [11] = '{32'h87, 32'h88, 0, 0, 32'h7ff, 0, 0, 32'h28, 0, 0, 0};
	logic [31:0] cct [11] = '{32'h7, 32'h7, 32'hf, 32'hf, 32'hf, 32'h3, 32'hf, 32'h13, 32'h3, 3,
		32'h2};
	dac_descriptor_access_check DUT (.sys_clk(sysClk), .rst(rst), .address(address),
		.read(read), .write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .faultOut(faultOut));
	dac_host_model HOST (.sys_clk(sysClk), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
	initial begin
		sysClk = 1'b0;
		forever #2 sysClk = ~sysClk;
	end
	// ----------------------------------------
	// expectations
	// ----------------------------------------
	function automatic logic permits(input logic [31:0] w0, input logic [31:0] c);
		logic [1:0] p;
		p = w0[24 + 2 * c[1:0] +: 2];
		case (c[4:2])
			3'h0, 3'h3: return p == 2'h3;
			3'h1, 3'h2, 3'h7: return p[1];
			default: return p != 2'h0;
		endcase
	endfunction
	function automatic logic [31:0] expStat(input logic [31:0] w0, pg, va, c);
		logic [31:0] s;
		s = 32'h1;
		if (!w0[6]) s[2] = 1'b1;
		else if (w0[7]) s[3] = 1'b1;
		else if (!permits(w0, c)) s[1] = 1'b1;
		else if (va[16:3] > w0[23:10]) s[4] = 1'b1;
		else if (w0[2]) s[5] = w0[4];
		else if (!pg[0]) s[6] = 1'b1;
		else if (pg[4] && (c[4:2] == 3'h3 || c[4:2] == 3'h0)) s[7] = 1'b1;
		else if (pg[2] && va[10:3] > w0[17:10]) s[4] = 1'b1;
		return s;
	endfunction
	function automatic logic [31:0] expAddr(input logic [31:0] w0, w1, pg, va);
		if (w0[7]) return {w1[31:3], 3'h0};
		if (w0[2]) return {w1[31:5], 5'h00} + {15'h0, va[16:0]};
		return {pg[31:11], va[10:0]};
	endfunction
	// ----------------------------------------
	// checks and bus access
	// ----------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp) begin
			failCount++;
			$display("MISMATCH at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic closeOut();
		$display("checks %0d mismatches %0d", checkCount, failCount);
		if (failCount == 0 && checkCount > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic bus(input logic isWr, input logic [7:0] a, input logic [31:0] d);
		HOST.xfer(isWr, a, d, rd);
		if (HOST.hung) begin
			failCount++;
			closeOut();
		end
	endtask
	task automatic translate();
		logic [31:0] mw;
		bus(1'b1, `DAC_OFS_CFG, cfgW);
		bus(1'b1, `DAC_OFS_SEGW0, segW0);
		bus(1'b1, `DAC_OFS_SEGW1, segW1);
		bus(1'b1, `DAC_OFS_PAGEW, pageW);
		bus(1'b1, `DAC_OFS_VADDR, vaddr);
		bus(1'b1, `DAC_OFS_CTRL, ctrlW | 32'h80000000);
		bus(1'b0, `DAC_OFS_STATUS, 32'h0);
		st = expStat(segW0, pageW, vaddr, ctrlW);
		check(rd & 32'hff, st);
		check({31'h0, faultOut}, {31'h0, |(st & 32'hf6)});
		if (st == 32'h1 && !segW0[2]) begin
			mw = {29'h0, pageW[2], pageW[1] | (ctrlW[4:2] == 3'h3) | (ctrlW[4:2] == 3'h0),
				segW0[5] & cfgW[0]};
			check({29'h0, rd[10:8]}, mw);
		end
		if ((st & 32'hf7) == 32'h1) begin
			bus(1'b0, `DAC_OFS_PADDR, 32'h0);
			check(rd, expAddr(segW0, segW1, pageW, vaddr));
		end
	endtask
	initial begin
		seed = 10;
		failCount = 0;
		checkCount = 0;
		rst = 1'b1;
		repeat (6) @(posedge sysClk);
		rst <= 1'b0;
		@(posedge sysClk);
		// reset values, unmapped space
		bus(1'b0, `DAC_OFS_CTRL, 32'h0);
		check(rd, 32'h0);
		bus(1'b0, `DAC_OFS_CFG, 32'h0);
		check(rd, 32'h0);
		bus(1'b1, 8'h2c, 32'hffffffff);
		bus(1'b0, 8'h2c, 32'h0);
		check(rd, 32'h0);
		// caches refuse access outside peripheral mode
		for (int m = 0; m < 2; m++) begin
			bus(1'b1, `DAC_OFS_CTRL, {26'h0, m[0], 5'h0});
			for (int k = 0; k < 2; k++) begin
				bus(1'b1, `DAC_OFS_CSEL, k ? 32'h7f : 32'h1f);
				bus(1'b1, `DAC_OFS_CLO, 32'h5a5a0000 + 32'(k));
				bus(1'b1, `DAC_OFS_CHI, 32'hc3c30000 + 32'(k));
				bus(1'b0, `DAC_OFS_CLO, 32'h0);
				check(rd, m ? 32'h5a5a0000 + 32'(k) : 32'h0);
				bus(1'b0, `DAC_OFS_CHI, 32'h0);
				check(rd, m ? 32'hc3c30000 + 32'(k) : 32'h0);
			end
		end
		// corner cases: length edge, trap, paged faults, indirect, invalid
		segW1 = 32'h00123460;
		for (int i = 0; i < 11; i++) begin
			segW0 = cw0[i];
			pageW = cpg[i];
			vaddr = cva[i];
			ctrlW = cct[i];
			cfgW = 32'(i[0]);
			translate();
		end
		// random descriptors; reserved bits kept clear by the software side
		for (int i = 0; i < 60; i++) begin
			segW0 = $random(seed) & 32'hfffffcff;
			segW1 = $random(seed);
			pageW = $random(seed) & 32'hffffff37;
			vaddr = $random(seed);
			ctrlW = $random(seed) & 32'h1f;
			cfgW = $random(seed) & 32'h3;
			translate();
		end
		closeOut();
	end
endmodule
